/* common/cwp_map.svh */
// register offsets, field positions, reset values and period decode codes for the config word decoder
// What this block does
// - Watchdog mode 11: run awake and asleep, software enable ignored.
// - Watchdog mode 10: run awake, suspend in sleep, software enable ignored.
// - Watchdog mode 01: software enable alone switches the watchdog.
// - Watchdog mode 00: watchdog off, software enable ignored.
// - Period codes 0..18 divide by 2^(5+code); codes 19..30 divide by 32.
// - Period code 31 gives software the period, default divider 2^16.
// - Clearing the low-voltage programming bit is refused during low-voltage programming.
// - Low-voltage programming on forces master clear; off needs high voltage.
// - Storage flash writes blocked while its lock bit is zero.
// - EEPROM writes blocked while its lock bit is zero.
// - Configuration writes blocked while its lock bit is zero.
// - Boot region writes blocked while its lock bit is zero.
// - Application region writes blocked while its lock bit is zero.
// - Lock and enable bits stick at zero until bulk erase.
// - Storage flash enabled when its enable bit is zero.
// - Boot region enabled when bit zero; otherwise its size is zero.
// - Boot size codes 111/110/101 give 512/1024/2048; lower codes give 4096.
// - Boot size field writable only while boot region disabled.
// - Boot size clamped to half the user program memory.
// - Code protection enabled when its bit is zero.
`ifndef CWP_MAP_SVH
`define CWP_MAP_SVH
// byte addresses: printed offsets are not multiples of four, so index times four
`define CWP_IDX_WDT 16'h8009
`define CWP_IDX_MWP 16'h800a
`define CWP_IDX_CPW 16'h800b
`define CWP_IDX_CTL 16'h800c
`define CWP_ADDR_WDT 18'h20024
`define CWP_ADDR_MWP 18'h20028
`define CWP_ADDR_CPW 18'h2002c
`define CWP_ADDR_CTL 18'h20030
// erased word value
`define CWP_ERASED 14'h3fff
// watchdog word fields
`define CWP_WDT_MODE_LSB 5
`define CWP_WDT_PER_LSB 0
// memory protection word fields
`define CWP_LVP_BIT 13
`define CWP_SAFWL_BIT 11
`define CWP_EEWL_BIT 10
`define CWP_CFGWL_BIT 9
`define CWP_BOOTWL_BIT 8
`define CWP_APPWL_BIT 7
`define CWP_STORAGE_FLASH_ENABLE_BIT 4
`define CWP_BOOT_REGION_ENABLE_BIT 3
`define CWP_BBSZ_LSB 0
// bits that only move toward zero between bulk erases
`define CWP_STICKY_MASK 14'h0f98
// code protect bit
`define CWP_CP_BIT 0
// control register bits
`define CWP_CTL_ERASE_BIT 0
// period decode
`define CWP_PER_SW 5'h1f
`define CWP_PER_DEFAULT 5'h0b
`define CWP_PER_MAXDIV 5'h12
`define CWP_PER_BASE 5'h05
`endif

/* common/cwp_pkg.sv */
// types for the config word decoder
package cwp_pkg;
  typedef enum logic [1:0] {
    CWP_WDT_OFF = 2'b00,
    CWP_WDT_SW = 2'b01,
    CWP_WDT_AWAKE = 2'b10,
    CWP_WDT_ON = 2'b11
  } cwp_wdt_mode_t;
  typedef enum logic [1:0] {
    CWP_BUS_IDLE = 2'b00,
    CWP_BUS_WRITE = 2'b01,
    CWP_BUS_READ = 2'b10
  } cwp_bus_state_t;
endpackage

/* design/cwp_wdt_decode.sv */
// watchdog mode and period decode from the watchdog word
`timescale 1ns/10ps
`default_nettype none
`include "cwp_map.svh"
module cwp_wdt_decode (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // configuration and state
  input wire logic [13:0] wdt_word_in,
  input wire logic software_watchdog_enable_in,
  input wire logic sleep_in,
  // decoded results
  output logic wdt_run_out,
  output logic [4:0] wdt_div_exp_out,
  output logic wdt_sw_period_out
);
  cwp_pkg::cwp_wdt_mode_t mode;
  logic [4:0] code;
  logic [4:0] exp_nxt;
  logic run_nxt;

  // ****************************************
  // decode
  // ****************************************
  // mode and period decode
  always_comb begin
    mode = cwp_pkg::cwp_wdt_mode_t'(wdt_word_in[`CWP_WDT_MODE_LSB +: 2]);
    code = wdt_word_in[`CWP_WDT_PER_LSB +: 5];
    unique case (mode)
      cwp_pkg::CWP_WDT_ON: run_nxt = 1'b1;
      cwp_pkg::CWP_WDT_AWAKE: run_nxt = !sleep_in;
      cwp_pkg::CWP_WDT_SW: run_nxt = software_watchdog_enable_in;
      cwp_pkg::CWP_WDT_OFF: run_nxt = 1'b0;
    endcase
    if (code == `CWP_PER_SW) begin
      exp_nxt = `CWP_PER_BASE + `CWP_PER_DEFAULT;
    end else if (code <= `CWP_PER_MAXDIV) begin
      exp_nxt = `CWP_PER_BASE + code;
    end else begin
      exp_nxt = `CWP_PER_BASE;
    end
  end

  // registered outputs
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wdt_run_out <= 1'b0;
      wdt_div_exp_out <= 5'h00;
      wdt_sw_period_out <= 1'b0;
    end else begin
      wdt_run_out <= run_nxt;
      wdt_div_exp_out <= exp_nxt;
      wdt_sw_period_out <= (code == `CWP_PER_SW);
    end
  end

  a_run_follows_mode: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ##1 (wdt_word_in[6:5] == 2'b00) |=> !wdt_run_out)
    else $error("watchdog runs in off mode");
  a_period_default: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !$past(sys_rst_in) && (wdt_word_in[4:0] == 5'h1f)
    |=> (wdt_div_exp_out == 5'h10) && wdt_sw_period_out)
    else $error("software period code gave wrong divider");
  a_period_high: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (wdt_word_in[4:0] > 5'h12 && wdt_word_in[4:0] != 5'h1f) |=> (wdt_div_exp_out == 5'h05))
    else $error("high period code not 1:32");
  a_period_low: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (wdt_word_in[4:0] <= 5'h12) |=> (wdt_div_exp_out == $past(wdt_word_in[4:0]) + 5'h05))
    else $error("period divider wrong");
  a_awake_sleep: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (wdt_word_in[6:5] == 2'b10) && sleep_in |=> !wdt_run_out)
    else $error("watchdog ran in sleep");
  a_always_on: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !$past(sys_rst_in) && (wdt_word_in[6:5] == 2'b11) |=> wdt_run_out)
    else $error("watchdog not running in on mode");
  a_sw_mode: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (wdt_word_in[6:5] == 2'b01) |=> (wdt_run_out == $past(software_watchdog_enable_in)))
    else $error("software enable not followed");
endmodule
`default_nettype wire

/* design/cwp_config_words.sv */
// config word store with protection decode and an AHB-Lite register slave
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "cwp_map.svh"
module cwp_config_words #(
  parameter int USER_MEM_WORDS = 8192
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // device state pins
  input wire logic software_watchdog_enable_in,
  input wire logic sleep_in,
  input wire logic lv_programming_in,
  input wire logic master_clear_pin_enable_in,
  // decoded controls
  output logic wdt_run_out,
  output logic [4:0] wdt_div_exp_out,
  output logic wdt_sw_period_out,
  output logic mclr_function_out,
  output logic hv_program_required_out,
  output logic saf_write_block_out,
  output logic eeprom_write_block_out,
  output logic config_write_block_out,
  output logic boot_write_block_out,
  output logic app_write_block_out,
  output logic saf_enabled_out,
  output logic boot_enabled_out,
  output logic [12:0] boot_size_out,
  output logic code_protect_out
);
  localparam logic [12:0] HALF_WORDS = 13'(USER_MEM_WORDS / 2);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic swen_s;
  logic sleep_s;
  logic lvp_mode_s;
  logic master_clear_pin_enable_s;

  // two flops on each pin input
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
    end else begin
      pin_s1_r <= {software_watchdog_enable_in, sleep_in, lv_programming_in,
                   master_clear_pin_enable_in};
      pin_s2_r <= pin_s1_r;
    end
  end
  assign {swen_s, sleep_s, lvp_mode_s, master_clear_pin_enable_s} = pin_s2_r;

  // ****************************************
  // bus slave
  // ****************************************
  cwp_pkg::cwp_bus_state_t bus_state_r;
  logic [17:0] addr_r;
  logic take;

  assign take = hsel_in && hready_in && htrans_in[1];

  // address phase capture, zero wait states
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      bus_state_r <= cwp_pkg::CWP_BUS_IDLE;
      addr_r <= 18'h00000;
    end else if (take) begin
      bus_state_r <= hwrite_in ? cwp_pkg::CWP_BUS_WRITE : cwp_pkg::CWP_BUS_READ;
      addr_r <= haddr_in[17:0];
    end else begin
      bus_state_r <= cwp_pkg::CWP_BUS_IDLE;
    end
  end

  // slave is always ready and always okay
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
  end

  // ****************************************
  // configuration words
  // ****************************************
  logic [13:0] wdt_word_r;
  logic [13:0] mwp_word_r;
  logic [13:0] cpw_word_r;
  logic wr_wdt;
  logic wr_mwp;
  logic wr_cpw;
  logic wr_erase;
  logic [13:0] wd;
  logic [13:0] mwp_nxt;
  logic [13:0] wdt_new;
  logic [13:0] mwp_new;
  logic [13:0] cpw_new;
  logic cfg_open;

  assign wd = hwdata_in[13:0];
  assign cfg_open = mwp_word_r[`CWP_CFGWL_BIT];
  assign wr_wdt = (bus_state_r == cwp_pkg::CWP_BUS_WRITE) && (addr_r == `CWP_ADDR_WDT);
  assign wr_mwp = (bus_state_r == cwp_pkg::CWP_BUS_WRITE) && (addr_r == `CWP_ADDR_MWP);
  assign wr_cpw = (bus_state_r == cwp_pkg::CWP_BUS_WRITE) && (addr_r == `CWP_ADDR_CPW);
  assign wr_erase = (bus_state_r == cwp_pkg::CWP_BUS_WRITE) && (addr_r == `CWP_ADDR_CTL)
                    && hwdata_in[`CWP_CTL_ERASE_BIT];

  // next protection word: sticky bits only fall, size frozen once boot is on
  always_comb begin
    mwp_nxt = wd & (mwp_word_r | ~`CWP_STICKY_MASK);
    if (lvp_mode_s && mwp_word_r[`CWP_LVP_BIT]) begin
      mwp_nxt[`CWP_LVP_BIT] = 1'b1;
    end
    if (!mwp_word_r[`CWP_BOOT_REGION_ENABLE_BIT]) begin
      mwp_nxt[`CWP_BBSZ_LSB +: 3] = mwp_word_r[`CWP_BBSZ_LSB +: 3];
    end
  end

  // word values after this edge; bulk erase returns all to the erased value
  always_comb begin
    wdt_new = wdt_word_r;
    mwp_new = mwp_word_r;
    cpw_new = cpw_word_r;
    if (wr_erase) begin
      wdt_new = `CWP_ERASED;
      mwp_new = `CWP_ERASED;
      cpw_new = `CWP_ERASED;
    end else if (cfg_open) begin
      if (wr_wdt) begin
        wdt_new = wd;
      end
      if (wr_mwp) begin
        mwp_new = mwp_nxt;
      end
      if (wr_cpw) begin
        cpw_new = {13'h1fff, wd[`CWP_CP_BIT]}; // unimplemented bits read one
      end
    end
  end

  // word storage
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wdt_word_r <= `CWP_ERASED;
      mwp_word_r <= `CWP_ERASED;
      cpw_word_r <= `CWP_ERASED;
    end else begin
      wdt_word_r <= wdt_new;
      mwp_word_r <= mwp_new;
      cpw_word_r <= cpw_new;
    end
  end

  // read data registered at the address phase; a write landing now is forwarded
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      hrdata_out <= 32'h00000000;
    end else if (take && !hwrite_in) begin
      case (haddr_in[17:0])
        `CWP_ADDR_WDT: hrdata_out <= {18'h00000, wdt_new};
        `CWP_ADDR_MWP: hrdata_out <= {18'h00000, mwp_new};
        `CWP_ADDR_CPW: hrdata_out <= {18'h00000, cpw_new};
        default: hrdata_out <= 32'h00000000; // unmapped reads zero
      endcase
    end
  end

  // ****************************************
  // protection decode
  // ****************************************
  logic [12:0] size_nxt;
  logic [2:0] bbsz;

  assign bbsz = mwp_word_r[`CWP_BBSZ_LSB +: 3];

  // boot region size lookup with half-memory clamp
  always_comb begin
    if (mwp_word_r[`CWP_BOOT_REGION_ENABLE_BIT]) begin
      size_nxt = 13'h0000;
    end else begin
      unique case (bbsz)
        3'h7: size_nxt = 13'h0200;
        3'h6: size_nxt = 13'h0400;
        3'h5: size_nxt = 13'h0800;
        default: size_nxt = 13'h1000;
      endcase
      if (size_nxt > HALF_WORDS) begin
        size_nxt = HALF_WORDS;
      end
    end
  end

  // registered protection outputs
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mclr_function_out <= 1'b1;
      hv_program_required_out <= 1'b0;
      saf_write_block_out <= 1'b0;
      eeprom_write_block_out <= 1'b0;
      config_write_block_out <= 1'b0;
      boot_write_block_out <= 1'b0;
      app_write_block_out <= 1'b0;
      saf_enabled_out <= 1'b0;
      boot_enabled_out <= 1'b0;
      boot_size_out <= 13'h0000;
      code_protect_out <= 1'b0;
    end else begin
      mclr_function_out <= mwp_word_r[`CWP_LVP_BIT] | master_clear_pin_enable_s;
      hv_program_required_out <= !mwp_word_r[`CWP_LVP_BIT];
      saf_write_block_out <= !mwp_word_r[`CWP_SAFWL_BIT];
      eeprom_write_block_out <= !mwp_word_r[`CWP_EEWL_BIT];
      config_write_block_out <= !mwp_word_r[`CWP_CFGWL_BIT];
      boot_write_block_out <= !mwp_word_r[`CWP_BOOTWL_BIT];
      app_write_block_out <= !mwp_word_r[`CWP_APPWL_BIT];
      saf_enabled_out <= !mwp_word_r[`CWP_STORAGE_FLASH_ENABLE_BIT];
      boot_enabled_out <= !mwp_word_r[`CWP_BOOT_REGION_ENABLE_BIT];
      boot_size_out <= size_nxt;
      code_protect_out <= !cpw_word_r[`CWP_CP_BIT];
    end
  end

  // ****************************************
  // watchdog decode
  // ****************************************
  cwp_wdt_decode u_wdt (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .wdt_word_in(wdt_word_r),
    .software_watchdog_enable_in(swen_s),
    .sleep_in(sleep_s),
    .wdt_run_out(wdt_run_out),
    .wdt_div_exp_out(wdt_div_exp_out),
    .wdt_sw_period_out(wdt_sw_period_out)
  );

  // ****************************************
  // checks
  // ****************************************
  a_lvp_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    lvp_mode_s && mwp_word_r[13] && !wr_erase |=> mwp_word_r[13])
    else $error("low-voltage bit cleared during lv programming");
  a_sticky_fall: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !wr_erase |=> ((mwp_word_r & 14'h0f98) & ~$past(mwp_word_r)) == 14'h0000)
    else $error("sticky bit rose without erase");
  a_size_frozen: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !mwp_word_r[3] && !wr_erase |=> $stable(mwp_word_r[2:0]))
    else $error("boot size changed while enabled");
  a_cfg_locked: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !mwp_word_r[9] && !wr_erase |=> $stable(wdt_word_r) && $stable(cpw_word_r))
    else $error("config word written while locked");
  a_boot_off_size: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    mwp_word_r[3] |=> boot_size_out == 13'h0000)
    else $error("boot size not zero while disabled");
  a_boot_small: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !mwp_word_r[3] && mwp_word_r[2:0] == 3'h7 |=> boot_size_out == 13'h0200)
    else $error("boot size 512 wrong");
  a_boot_clamp: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ##1 boot_size_out <= HALF_WORDS)
    else $error("boot size over half memory");
  a_saf_block: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !mwp_word_r[11] |=> saf_write_block_out)
    else $error("storage flash not blocked");
  a_eeprom_block: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !mwp_word_r[10] |=> eeprom_write_block_out)
    else $error("eeprom not blocked");
  a_region_block: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ##1 boot_write_block_out == !$past(mwp_word_r[8])
    && app_write_block_out == !$past(mwp_word_r[7]))
    else $error("region lock mismatch");
  a_saf_enable: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ##1 saf_enabled_out == !$past(mwp_word_r[4]))
    else $error("storage flash enable mismatch");
  a_code_protect: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ##1 code_protect_out == !$past(cpw_word_r[0]))
    else $error("code protect mismatch");
  a_mclr_lvp: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    mwp_word_r[13] |=> mclr_function_out && !hv_program_required_out)
    else $error("lv programming mclr function wrong");
  c_erase: cover property (@(posedge clk_in) wr_erase);
  c_boot_on: cover property (@(posedge clk_in) boot_enabled_out);
  c_cfg_lock: cover property (@(posedge clk_in) config_write_block_out && wr_wdt);
  c_lvp_refuse: cover property (@(posedge clk_in) lvp_mode_s && wr_mwp && !wd[13]);
endmodule
`default_nettype wire

/* tb/cwp_ahb_host.sv */
// ahb-lite master standing in for the device programmer
`timescale 1ns/10ps
`default_nettype none
module cwp_ahb_host (
  // clock
  input wire logic clk_in,
  // answer from the slave
  input wire logic hready_in,
  input wire logic [31:0] hrdata_in,
  // request to the slave
  output logic hsel_out,
  output logic [31:0] haddr_out,
  output logic [1:0] htrans_out,
  output logic hwrite_out,
  output logic [2:0] hsize_out,
  output logic [31:0] hwdata_out
);
  // ******
  // idle bus and single word transfers
  // ******
  // bus starts idle
  initial begin
    hsel_out = 1'b0;
    haddr_out = 32'h0;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out = 3'h2;
    hwdata_out = 32'h0;
  end
  // address phase held until ready, then data phase held until ready
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_in);
    hsel_out <= 1'b1;
    haddr_out <= a;
    htrans_out <= 2'h2;
    hwrite_out <= wr;
    hsize_out <= 3'h2;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    hsel_out <= 1'b0;
    htrans_out <= 2'h0;
    haddr_out <= ~a; // released address scrambled
    hwdata_out <= d;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    q = hrdata_in;
    hwdata_out <= ~d; // released data scrambled
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the config word decoder
`timescale 1ns/10ps
`default_nettype none
`include "cwp_map.svh"
module tb;
  // ******
  // signals and model state
  // ******
  localparam int HALF_WORDS = 2048;
  localparam int LIMIT = 60000;
  // clock, reset and bus
  logic clk_in, sys_rst_in, hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  // device pins and decoded results
  logic swen, sleep, lvprog, master_clear_pin_enable, run, swper, mclr, hv, b_saf, b_ee, b_cfg, b_boot, b_app;
  logic storage_flash_enable, booten, cp;
  logic [4:0] dexp;
  logic [12:0] bsize;
  // model words, counters and random state
  int m_wdt, m_mwp, m_cp, i;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] seed, r;

  cwp_config_words #(.USER_MEM_WORDS(4096)) i_cwp_config_words (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .software_watchdog_enable_in(swen), .sleep_in(sleep), .lv_programming_in(lvprog),
    .master_clear_pin_enable_in(master_clear_pin_enable), .wdt_run_out(run), .wdt_div_exp_out(dexp),
    .wdt_sw_period_out(swper), .mclr_function_out(mclr), .hv_program_required_out(hv),
    .saf_write_block_out(b_saf), .eeprom_write_block_out(b_ee),
    .config_write_block_out(b_cfg), .boot_write_block_out(b_boot),
    .app_write_block_out(b_app), .saf_enabled_out(storage_flash_enable), .boot_enabled_out(booten),
    .boot_size_out(bsize), .code_protect_out(cp));

  cwp_ahb_host i_cwp_ahb_host (
    .clk_in(clk_in), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel),
    .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
    .hwdata_out(hwdata));

  // ******
  // helpers
  // ******
  // xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // compare and count
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // pins change at an edge
  task automatic sp(input logic [3:0] p);
    @(posedge clk_in);
    swen <= p[0];
    sleep <= p[1];
    lvprog <= p[2];
    master_clear_pin_enable <= p[3];
  endtask
  // read one word and compare
  task automatic rd(input string n, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    i_cwp_ahb_host.xfer(1'b0, a, 32'h0, q);
    check(n, q, e);
  endtask
  // write one word and update the model
  task automatic wr(input logic [31:0] a, input int d);
    int n;
    logic [31:0] q;
    i_cwp_ahb_host.xfer(1'b1, a, d, q);
    n = d & 32'h3fff;
    if (a == `CWP_ADDR_CTL && d[0]) begin
      m_wdt = 32'h3fff;
      m_mwp = 32'h3fff;
      m_cp = 32'h3fff;
    end else if (m_mwp[9]) begin
      if (a == `CWP_ADDR_WDT) m_wdt = n;
      if (a == `CWP_ADDR_CPW) m_cp = n | 32'h3ffe;
      if (a == `CWP_ADDR_MWP) begin
        n = n & (m_mwp | ~32'h0f98);
        if (lvprog) n = n | (m_mwp & 32'h2000);
        if (!m_mwp[3]) n = (n & ~32'h7) | (m_mwp & 32'h7);
        m_mwp = n;
      end
    end
  endtask
  // every output and word against the model
  task automatic check_all();
    int c, dv, sz, md, ex;
    repeat (4) @(posedge clk_in);
    c = m_wdt & 31;
    md = (m_wdt >> 5) & 3;
    dv = (c == 31) ? 16 : (c > 18) ? 5 : c + 5;
    ex = (md == 3) ? 1 : (md == 2) ? !sleep : (md == 1) ? swen : 0;
    sz = (m_mwp & 7) == 7 ? 512 : (m_mwp & 7) == 6 ? 1024 : (m_mwp & 7) == 5 ? 2048 : 4096;
    if (sz > HALF_WORDS) sz = HALF_WORDS;
    if (m_mwp[3]) sz = 0;
    check("run", run, ex);
    check("div", dexp, dv);
    check("swper", swper, c == 31);
    check("mclr", mclr, m_mwp[13] | master_clear_pin_enable);
    check("hv", hv, !m_mwp[13]);
    check("safwb", b_saf, !m_mwp[11]);
    check("eewb", b_ee, !m_mwp[10]);
    check("cfgwb", b_cfg, !m_mwp[9]);
    check("bootwb", b_boot, !m_mwp[8]);
    check("appwb", b_app, !m_mwp[7]);
    check("storage_flash_enable", storage_flash_enable, !m_mwp[4]);
    check("booten", booten, !m_mwp[3]);
    check("bsize", bsize, sz);
    check("cp", cp, !m_cp[0]);
    check("resp", {hresp, hready}, 32'h1);
    rd("wdtw", `CWP_ADDR_WDT, m_wdt);
    rd("mwpw", `CWP_ADDR_MWP, m_mwp);
    rd("cpw", `CWP_ADDR_CPW, m_cp);
  endtask
  // verdict and end of run
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ******
  // clock, timeout and tests
  // ******
  // free running clock
  always #50 clk_in = ~clk_in;
  // hang guard
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      end_of_test();
    end
  end
  // main sequence
  initial begin
    clk_in = 1'b0;
    sys_rst_in = 1'b1;
    {swen, sleep, lvprog, master_clear_pin_enable} = 4'h0;
    seed = 32'h1562dea5;
    m_wdt = 32'h3fff;
    m_mwp = 32'h3fff;
    m_cp = 32'h3fff;
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    check_all();
    rd("unmapped", 32'h20034, 32'h0);
    rd("ctl", `CWP_ADDR_CTL, 32'h0);
    $display("test reset done");
    // every mode against every pin pair
    for (i = 0; i < 16; i++) begin
      sp({i[0], 1'b0, i[1], i[0]});
      wr(`CWP_ADDR_WDT, 32'h3f8b | ((i >> 2) << 5));
      check_all();
    end
    // every period code
    for (i = 0; i < 32; i++) begin
      wr(`CWP_ADDR_WDT, 32'h3fe0 | i);
      check_all();
    end
    $display("test watchdog done");
    // boot size set, enabled, then a refused resize
    for (i = 0; i < 8; i++) begin
      wr(`CWP_ADDR_CTL, 1);
      wr(`CWP_ADDR_MWP, 32'h3ff8 | i);
      check_all();
      wr(`CWP_ADDR_MWP, 32'h3ff0 | i);
      wr(`CWP_ADDR_MWP, 32'h3ff0 | (~i & 7));
      check_all();
    end
    $display("test boot done");
    // low-voltage bit refused during low-voltage programming
    wr(`CWP_ADDR_CTL, 1);
    sp(4'h4);
    check_all();
    wr(`CWP_ADDR_MWP, 32'h1fff);
    check_all();
    sp(4'h0);
    check_all();
    wr(`CWP_ADDR_MWP, 32'h1fff);
    check_all();
    sp(4'h8);
    check_all();
    $display("test lvp done");
    // sticky bits, then config lock freezing all words, then erase
    wr(`CWP_ADDR_CTL, 1);
    wr(`CWP_ADDR_CPW, 32'h3ffe);
    for (i = 0; i < 14; i++) if (i inside {11, 10, 8, 7, 4}) begin
      wr(`CWP_ADDR_MWP, 32'h3fff & ~(32'h1 << i));
      wr(`CWP_ADDR_MWP, 32'h3fff);
      check_all();
    end
    wr(`CWP_ADDR_MWP, 32'h3dff);
    wr(`CWP_ADDR_WDT, 32'h3f80);
    wr(`CWP_ADDR_CPW, 32'h3fff);
    wr(`CWP_ADDR_MWP, 32'h3fff);
    check_all();
    wr(`CWP_ADDR_CTL, 1);
    check_all();
    $display("test locks done");
    // random pins and writes
    repeat (300) begin
      r = rnd();
      sp(r[3:0]);
      check_all();
      case (r[9:8])
        2'h0: wr(`CWP_ADDR_WDT, rnd() | 32'h3f80);
        2'h1: wr(`CWP_ADDR_MWP, rnd() | rnd() | 32'h1060);
        2'h2: wr(`CWP_ADDR_CPW, rnd());
        default: wr(r[10] ? 32'h20034 : `CWP_ADDR_CTL, {31'h0, r[12] & r[13]});
      endcase
    end
    check_all();
    $display("test random done");
    end_of_test();
  end
endmodule
`default_nettype wire
